// ==== rtl/flow_avg_consts.vh ====
// Constants for the flow measurement sequencing and averaging block.
// Assumes a 25 MHz clock; included by the averaging module's design file only.
`ifndef FLOW_AVG_CONSTS_VH
`define FLOW_AVG_CONSTS_VH

`define CLK_HZ 25000000
`define SAMPLE_NS 500000
`define SAMPLE_CYC (`SAMPLE_NS / 40)
`define READY_MS 2
`define READY_CYC (`READY_MS * (`CLK_HZ / 1000))
`define FIRST_MS 12
`define FIRST_CYC (`FIRST_MS * (`CLK_HZ / 1000))
`define WARM_MS 30
`define WARM_CYC (`WARM_MS * (`CLK_HZ / 1000))
`define MEAN_MS 64
`define MEAN_SAMPLES (`MEAN_MS * 2)
`define TEMP_EVERY 16
`define MAX_COUNT 8'h80
`define CMD_PRODUCT_INFO 16'hE102
`define SMOOTH_NUM 7'h02
`define SMOOTH_DEN 7'h64

`endif

// ==== rtl/mean_divider.v ====
// Sequential signed divider for the averaging block.
// Assumes a start pulse only when idle; one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module mean_divider (
    input wire clk_in, // System clock.
    input wire rst_in, // Synchronous reset, active high.
    input wire start_in, // Pulse starting a division.
    input wire signed [31:0] num_in, // Signed dividend.
    input wire [15:0] den_in, // Divisor, never zero.
    output reg busy_out, // High while dividing.
    output reg done_out, // Pulse when quotient valid.
    output reg signed [15:0] quot_out // Signed quotient, saturated.
);
    reg [31:0] rem_reg;
    reg [31:0] mag_reg;
    reg [31:0] q_reg;
    reg neg_reg;
    reg [5:0] step_reg;
    wire [32:0] trial;
    wire signed [32:0] sq;

    assign trial = {rem_reg, mag_reg[31]} - {17'h00000, den_in};
    assign sq = neg_reg ? -$signed({1'b0, q_reg}) : $signed({1'b0, q_reg});

    // Restoring division on magnitudes, sign applied at the end.
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        if (rst_in) begin
            busy_out <= 1'b0;
            rem_reg <= 32'h00000000;
            mag_reg <= 32'h00000000;
            q_reg <= 32'h00000000;
            neg_reg <= 1'b0;
            step_reg <= 6'h00;
            quot_out <= 16'h0000;
        end else if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            neg_reg <= num_in[31];
            mag_reg <= num_in[31] ? 32'h00000000 - num_in : num_in;
            rem_reg <= 32'h00000000;
            q_reg <= 32'h00000000;
            step_reg <= 6'h20;
        end else if (busy_out && step_reg != 6'h00) begin
            mag_reg <= {mag_reg[30:0], 1'b0};
            if (!trial[32]) begin
                rem_reg <= trial[31:0];
                q_reg <= {q_reg[30:0], 1'b1};
            end else begin
                rem_reg <= {rem_reg[30:0], mag_reg[31]};
                q_reg <= {q_reg[30:0], 1'b0};
            end
            step_reg <= step_reg - 6'h01;
        end else if (busy_out) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            if (sq > 33'sd32767)
                quot_out <= 16'h7FFF;
            else if (sq < -33'sd32768)
                quot_out <= 16'h8000;
            else
                quot_out <= sq[15:0];
        end
    end
endmodule // mean_divider
`default_nettype wire

// ==== rtl/flow_averaging.v ====
// Measurement sequencing and flow averaging for a digital gas flow meter.
// Assumes a command decoder that pulses commands, raw sensor samples from
// the analog front end, and an AHB-Lite master for software access.
`timescale 1ns/1ps
`default_nettype none
`include "flow_avg_consts.vh"
module flow_averaging (
    input wire clk_in, // 25 MHz system clock.
    input wire rst_in, // Synchronous reset, active high.
    input wire scl_in, // Serial clock pin level, asynchronous.
    input wire crc_ok_in, // Memory checksum result, asynchronous.
    input wire crc_done_in, // Memory check finished, asynchronous.
    input wire signed [15:0] raw_flow_in, // Raw flow sample.
    input wire signed [15:0] raw_temp_in, // Raw temperature sample.
    input wire start_cmd_in, // Pulse: start continuous measurement.
    input wire [3:0] start_gas_in, // Gas code with start pulse.
    input wire stop_cmd_in, // Pulse: stop measurement.
    input wire soft_reset_in, // Pulse: soft reset command.
    input wire avg_cmd_in, // Pulse: averaging configuration.
    input wire [15:0] avg_arg_in, // Averaging count argument.
    input wire [15:0] cmd_code_in, // Received command code.
    input wire cmd_valid_in, // Pulse: command code valid.
    input wire read_hdr_in, // Pulse: read header addressed.
    input wire result_taken_in, // Pulse: flow word read out.
    input wire hsel, // AHB-Lite select.
    input wire [31:0] haddr, // AHB-Lite address.
    input wire [1:0] htrans, // AHB-Lite transfer type.
    input wire hwrite, // AHB-Lite write.
    input wire [2:0] hsize, // AHB-Lite size.
    input wire [31:0] hwdata, // AHB-Lite write data.
    input wire hready, // AHB-Lite bus ready.
    output reg [31:0] hrdata, // AHB-Lite read data.
    output reg hreadyout, // AHB-Lite slave ready.
    output reg hresp, // AHB-Lite response, always OKAY.
    output reg ready_out, // Bus interface may answer.
    output reg heater_out, // Heater enable.
    output reg warm_out, // Warm-up complete.
    output reg data_avail_out, // Result available.
    output reg hdr_ack_out, // Acknowledge of read header.
    output reg hdr_nack_out, // Not-acknowledge of read header.
    output reg prod_info_out, // Pulse: product info requested.
    output reg signed [15:0] flow_out, // Reported flow.
    output reg signed [15:0] temp_out, // Reported temperature.
    output reg [15:0] status_out // Status word.
);
    localparam ST_BOOT = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_INIT = 2'h2;
    localparam ST_RUN = 2'h3;
    localparam A_CTRL = 8'h00;
    localparam A_STAT = 8'h04;
    localparam A_FLOW = 8'h08;
    localparam A_TEMP = 8'h0C;
    localparam A_WORD = 8'h10;

    reg [1:0] state_reg;
    reg [2:0] scl_sync_reg;
    reg [2:0] crc_sync_reg;
    reg [2:0] crcd_sync_reg;
    reg scl_reg, crc_ok_reg, crc_done_reg;
    reg [23:0] timer_reg;
    reg [19:0] warm_reg;
    reg [13:0] tick_reg;
    reg fixed_reg;
    reg [7:0] count_reg;
    reg [7:0] n_reg;
    reg [3:0] gas_reg;
    reg smooth_reg;
    reg signed [31:0] sum_reg;
    reg signed [15:0] ema_reg;
    reg [3:0] temp_cnt_reg;
    reg div_start_reg;
    reg signed [31:0] div_num_reg;
    reg [15:0] div_den_reg;
    reg div_from_fixed_reg;
    reg ph_reg, ph_write_reg;
    reg [7:0] ph_addr_reg;
    wire div_busy, div_done;
    wire signed [15:0] div_quot;
    wire sample_tick;
    wire signed [31:0] ema_next;
    wire signed [31:0] raw_ext;
    wire signed [31:0] ema_ext;
    wire signed [31:0] ema_diff;

    assign sample_tick = (state_reg == ST_RUN) &&
        (tick_reg == `SAMPLE_CYC - 1);
    // Sign extension keeps the smoothing arithmetic signed and overflow free.
    assign raw_ext = {{16{raw_flow_in[15]}}, raw_flow_in};
    assign ema_ext = {{16{ema_reg[15]}}, ema_reg};
    assign ema_diff = raw_ext - ema_ext;
    // Smoothing step: S += 0.02 * (x - S).
    assign ema_next = ema_ext + (ema_diff * $signed({25'h0000000,
        `SMOOTH_NUM})) / $signed({25'h0000000, `SMOOTH_DEN});

    mean_divider u_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(div_start_reg),
        .num_in(div_num_reg),
        .den_in(div_den_reg),
        .busy_out(div_busy),
        .done_out(div_done),
        .quot_out(div_quot)
    );

    // Three-stage synchronisers for the asynchronous inputs.
    always @(posedge clk_in) begin
        if (rst_in) begin
            scl_sync_reg <= 3'h7;
            crc_sync_reg <= 3'h0;
            crcd_sync_reg <= 3'h0;
            scl_reg <= 1'b1;
            crc_ok_reg <= 1'b0;
            crc_done_reg <= 1'b0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            crc_sync_reg <= {crc_sync_reg[1:0], crc_ok_in};
            crcd_sync_reg <= {crcd_sync_reg[1:0], crc_done_in};
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_reg <= scl_sync_reg[2];
            if (crc_sync_reg[1] == crc_sync_reg[2])
                crc_ok_reg <= crc_sync_reg[2];
            if (crcd_sync_reg[1] == crcd_sync_reg[2])
                crc_done_reg <= crcd_sync_reg[2];
        end
    end

    // Sequencer: boot delay, idle, initialisation and running measurement.
    always @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= ST_BOOT;
            timer_reg <= 24'h000000;
            ready_out <= 1'b0;
            heater_out <= 1'b0;
            gas_reg <= 4'h0;
        end else begin
            case (state_reg)
            ST_BOOT: begin
                // Soft reset delay only advances with the clock line high.
                if (scl_reg)
                    timer_reg <= timer_reg + 24'h000001;
                if (timer_reg >= `READY_CYC - 1 && crc_done_reg &&
                    crc_ok_reg) begin
                    ready_out <= 1'b1;
                    state_reg <= ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (start_cmd_in) begin
                    heater_out <= 1'b1;
                    gas_reg <= start_gas_in;
                    timer_reg <= 24'h000000;
                    state_reg <= ST_INIT;
                end
            end
            ST_INIT: begin
                timer_reg <= timer_reg + 24'h000001;
                // First sample lands exactly at the 12 ms mark.
                if (timer_reg == `FIRST_CYC - `SAMPLE_CYC - 1)
                    state_reg <= ST_RUN;
            end
            default: begin
                if (stop_cmd_in) begin
                    heater_out <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            end
            endcase
            if (soft_reset_in) begin
                state_reg <= ST_BOOT;
                timer_reg <= 24'h000000;
                ready_out <= 1'b0;
                heater_out <= 1'b0;
            end
        end
    end

    // Sample tick and warm-up timer.
    always @(posedge clk_in) begin
        if (rst_in || state_reg == ST_IDLE || state_reg == ST_BOOT) begin
            tick_reg <= 14'h0000;
            warm_reg <= 20'h00000;
            warm_out <= 1'b0;
        end else begin
            if (state_reg == ST_RUN && !sample_tick)
                tick_reg <= tick_reg + 14'h0001;
            else
                tick_reg <= 14'h0000;
            if (warm_reg != `WARM_CYC - 1)
                warm_reg <= warm_reg + 20'h00001;
            else
                warm_out <= 1'b1;
        end
    end

    // Averaging: running sum, mean, smoothing and result latching.
    always @(posedge clk_in) begin
        div_start_reg <= 1'b0;
        if (rst_in || state_reg != ST_RUN) begin
            if (rst_in || soft_reset_in) begin
                fixed_reg <= 1'b0;
                n_reg <= 8'h00;
            end else if (avg_cmd_in && ready_out) begin
                // Averaging may be configured while idle as well.
                fixed_reg <= (avg_arg_in != 16'h0000);
                n_reg <= (avg_arg_in > {8'h00, `MAX_COUNT}) ? `MAX_COUNT :
                    avg_arg_in[7:0];
            end
            count_reg <= 8'h00;
            sum_reg <= 32'h00000000;
            smooth_reg <= 1'b0;
            ema_reg <= 16'h0000;
            temp_cnt_reg <= 4'h0;
            data_avail_out <= 1'b0;
            flow_out <= 16'h0000;
            temp_out <= 16'h0000;
            div_num_reg <= 32'h00000000;
            div_den_reg <= 16'h0001;
            div_from_fixed_reg <= 1'b0;
        end else begin
            if (sample_tick) begin
                temp_cnt_reg <= temp_cnt_reg + 4'h1;
                // The first sample and every sixteenth after it.
                if (temp_cnt_reg == 4'h0)
                    temp_out <= raw_temp_in;
                if (fixed_reg) begin
                    if (count_reg == n_reg - 8'h01) begin
                        div_num_reg <= sum_reg + raw_ext;
                        div_den_reg <= {8'h00, n_reg};
                        div_from_fixed_reg <= 1'b1;
                        div_start_reg <= 1'b1;
                        sum_reg <= 32'h00000000;
                        count_reg <= 8'h00;
                    end else begin
                        sum_reg <= sum_reg + raw_ext;
                        count_reg <= count_reg + 8'h01;
                    end
                end else if (smooth_reg) begin
                    ema_reg <= ema_next[15:0];
                    flow_out <= ema_next[15:0];
                    data_avail_out <= 1'b1;
                end else begin
                    sum_reg <= sum_reg + raw_ext;
                    div_num_reg <= sum_reg + raw_ext;
                    div_den_reg <= {8'h00, count_reg + 8'h01};
                    div_from_fixed_reg <= 1'b0;
                    div_start_reg <= 1'b1;
                    count_reg <= count_reg + 8'h01;
                    if (count_reg == `MEAN_SAMPLES - 1)
                        smooth_reg <= 1'b1;
                end
            end
            if (div_done) begin
                flow_out <= div_quot;
                data_avail_out <= 1'b1;
                if (!div_from_fixed_reg)
                    ema_reg <= div_quot;
            end
            // Outside fixed mode a read restarts the mean; a sample in the same cycle opens it.
            if (result_taken_in && !fixed_reg) begin
                smooth_reg <= 1'b0;
                data_avail_out <= 1'b0;
                if (sample_tick) begin
                    sum_reg <= raw_ext;
                    count_reg <= 8'h01;
                    div_num_reg <= raw_ext;
                    div_den_reg <= 16'h0001;
                    div_from_fixed_reg <= 1'b0;
                    div_start_reg <= 1'b1;
                end else begin
                    sum_reg <= 32'h00000000;
                    count_reg <= 8'h00;
                end
            end else if (result_taken_in && fixed_reg && !div_done)
                data_avail_out <= 1'b0;
            if (avg_cmd_in) begin
                fixed_reg <= (avg_arg_in != 16'h0000);
                n_reg <= (avg_arg_in > {8'h00, `MAX_COUNT}) ? `MAX_COUNT :
                    avg_arg_in[7:0];
                sum_reg <= 32'h00000000;
                count_reg <= 8'h00;
                smooth_reg <= 1'b0;
            end
        end
    end

    // Header answer, product information and status word.
    always @(posedge clk_in) begin
        if (rst_in) begin
            hdr_ack_out <= 1'b0;
            hdr_nack_out <= 1'b0;
            prod_info_out <= 1'b0;
            status_out <= 16'h0000;
        end else begin
            hdr_ack_out <= read_hdr_in && ready_out && data_avail_out;
            hdr_nack_out <= read_hdr_in &&
                !(ready_out && data_avail_out);
            prod_info_out <= cmd_valid_in && ready_out &&
                (cmd_code_in == `CMD_PRODUCT_INFO);
            status_out <= {gas_reg, smooth_reg, fixed_reg,
                10'h3FF};
        end
    end

    // AHB-Lite slave: zero wait states, OKAY response always.
    always @(posedge clk_in) begin
        if (rst_in) begin
            ph_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ph_reg <= hsel && hready && htrans[1];
            ph_write_reg <= hwrite;
            ph_addr_reg <= haddr[7:0];
            hrdata <= 32'h00000000;
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                A_CTRL: hrdata <= {23'h000000, fixed_reg, n_reg};
                A_STAT: hrdata <= {26'h0000000, state_reg, warm_out,
                    heater_out, data_avail_out, ready_out};
                A_FLOW: hrdata <= {{16{flow_out[15]}}, flow_out};
                A_TEMP: hrdata <= {{16{temp_out[15]}}, temp_out};
                A_WORD: hrdata <= {16'h0000, status_out};
                default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // flow_averaging
`default_nettype wire

// ==== tb/flow_averaging_chk.sv ====
// Checker for the flow averaging block: header answers, commands, timing.
// Assumes a 25 MHz clock; bound to every flow_averaging instance below.
`timescale 1ns/1ps
`default_nettype none
module flow_averaging_chk (
    input wire logic clk_in, // Clock.
    input wire logic rst_in, // Reset.
    input wire logic start_cmd_in, // Start pulse.
    input wire logic soft_reset_in, // Soft reset pulse.
    input wire logic cmd_valid_in, // Command code valid.
    input wire logic [15:0] cmd_code_in, // Command code.
    input wire logic read_hdr_in, // Read header pulse.
    input wire logic result_taken_in, // Flow word read out.
    input wire logic ready_out, // Bus may answer.
    input wire logic heater_out, // Heater enable.
    input wire logic warm_out, // Warm-up done.
    input wire logic data_avail_out, // Result available.
    input wire logic hdr_ack_out, // Header acknowledge.
    input wire logic hdr_nack_out, // Header refusal.
    input wire logic prod_info_out // Product info pulse.
);
    logic [19:0] rdy_cnt; // Cycles since the last reset of either kind.
    logic [19:0] run_cnt; // Cycles since the last start pulse.
    logic first_wait; // An accepted start still awaits its first result.
    // Counts the reset-to-ready and start-to-result intervals.
    always_ff @(posedge clk_in) begin
        if (rst_in || soft_reset_in) rdy_cnt <= 20'h0;
        else if (rdy_cnt != 20'hFFFFF) rdy_cnt <= rdy_cnt + 20'h1;
        if (start_cmd_in) run_cnt <= 20'h0;
        else if (run_cnt != 20'hFFFFF) run_cnt <= run_cnt + 20'h1;
        if (rst_in) first_wait <= 1'b0;
        else if (start_cmd_in && ready_out && !heater_out) first_wait <= 1'b1;
        else if (data_avail_out) first_wait <= 1'b0;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_start;
        start_cmd_in && ready_out && !heater_out;
    endsequence
    sequence s_first;
        $rose(data_avail_out) && first_wait;
    endsequence
    a_nack_empty: assert property (read_hdr_in && ready_out
        && !data_avail_out |=> hdr_nack_out && !hdr_ack_out)
        else $error("empty read header not refused");
    a_ack_data: assert property (read_hdr_in && ready_out
        && data_avail_out |=> hdr_ack_out && !hdr_nack_out)
        else $error("read header with data not acknowledged");
    a_prod_info: assert property (cmd_valid_in && ready_out
        && cmd_code_in == 16'hE102 |=> prod_info_out)
        else $error("product info command not answered");
    a_prod_cause: assert property (prod_info_out |->
        $past(cmd_valid_in) && $past(cmd_code_in) == 16'hE102)
        else $error("product info without its command");
    a_heater_on: assert property (s_start |=> heater_out)
        else $error("heater not on after start");
    a_heater_idle: assert property (!ready_out [*3] |-> !heater_out)
        else $error("heater on before ready");
    a_ready_time: assert property ($rose(ready_out) |->
        rdy_cnt >= 20'h0C350)
        else $error("ready too early after reset");
    a_first_time: assert property (s_first |->
        run_cnt >= 20'h493E0 && run_cnt <= 20'h49444)
        else $error("first result outside its window");
    a_taken_clear: assert property (result_taken_in
        && data_avail_out |=> !data_avail_out)
        else $error("result read out but still available");
    a_warm_time: assert property ($rose(warm_out) |->
        heater_out && run_cnt >= 20'hB71B0)
        else $error("warm-up flagged too early");
endmodule // flow_averaging_chk
bind flow_averaging flow_averaging_chk chk_u (.clk_in, .rst_in,
    .start_cmd_in, .soft_reset_in, .cmd_valid_in, .cmd_code_in,
    .read_hdr_in, .result_taken_in, .ready_out, .heater_out, .warm_out,
    .data_avail_out, .hdr_ack_out, .hdr_nack_out, .prod_info_out);
`default_nettype wire

// ==== tb/host_reader.sv ====
// Host model that reads results out of the flow averaging block.
// Assumes the block answers a read header one cycle after it.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    input wire logic clk_in, // Clock.
    input wire logic rst_in, // Reset.
    input wire logic en_in, // Reading allowed.
    input wire logic [7:0] lag_in, // Cycles before each read header.
    input wire logic avail_in, // Result available.
    input wire logic ack_in, // Header acknowledged.
    output logic rd_hdr_out, // Read header pulse.
    output logic taken_out, // Flow word read out.
    output logic [15:0] reads_out // Results taken.
);
    logic [1:0] st;
    logic [7:0] wt;
    // Waits, addresses the block, takes the flow word, waits for clearing.
    always_ff @(posedge clk_in) begin
        rd_hdr_out <= 1'b0;
        taken_out <= 1'b0;
        if (rst_in) begin
            st <= 2'h0;
            reads_out <= 16'h0;
        end else if (st == 2'h0) begin
            if (en_in && avail_in) begin
                wt <= lag_in;
                st <= 2'h1;
            end
        end else if (st == 2'h1) begin
            wt <= wt - 8'h1;
            if (wt == 8'h0) begin
                rd_hdr_out <= 1'b1;
                st <= 2'h2;
            end
        end else if (st == 2'h2) begin
            wt <= wt + 8'h1;
            if (ack_in) begin
                taken_out <= 1'b1;
                reads_out <= reads_out + 16'h1;
                st <= 2'h3;
            end else if (wt == 8'h3) st <= 2'h0;
        end else if (!avail_in) st <= 2'h0;
    end
endmodule // host_reader
`default_nettype wire

// ==== tb/flow_averaging_tb.sv ====
// Self-checking bench for the flow averaging block.
// Assumes the host model file and the checker file are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
end
module flow_averaging_tb;
    logic clk_in, rst_in, scl, hsel, hwrite, host_en, host_rd, taken;
    logic [5:0] cmd_v;
    logic [15:0] cmd_arg, raw_flow, raw_temp, reads;
    logic [31:0] haddr, hwdata, r;
    logic [1:0] htrans;
    wire [31:0] hrdata;
    wire hreadyout, hresp, ready_out, heater_out, warm_out, data_avail_out;
    wire hdr_ack_out, hdr_nack_out, prod_info_out;
    wire [15:0] flow_out, temp_out, status_out;
    int mismatches = 0, num_checks = 0, cyc = 0, t0, t1, t2;
    typedef struct {logic [15:0] arg; logic [31:0] cfg;} row_t;
    row_t rows[5] = '{'{16'h0001, 32'h101}, '{16'h0080, 32'h180},
        '{16'h0200, 32'h180}, '{16'h0005, 32'h105}, '{16'h0000, 32'h0}};
    flow_averaging dut_u (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl),
        .crc_ok_in(1'b1), .crc_done_in(1'b1), .raw_flow_in(raw_flow),
        .raw_temp_in(raw_temp), .start_cmd_in(cmd_v[0]), .start_gas_in(4'h1),
        .stop_cmd_in(cmd_v[1]), .soft_reset_in(cmd_v[2]),
        .avg_cmd_in(cmd_v[3]), .avg_arg_in(cmd_arg), .cmd_code_in(cmd_arg),
        .cmd_valid_in(cmd_v[4]), .read_hdr_in(cmd_v[5] | host_rd),
        .result_taken_in(taken), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ready_out(ready_out), .heater_out(heater_out),
        .warm_out(warm_out), .data_avail_out(data_avail_out),
        .hdr_ack_out(hdr_ack_out), .hdr_nack_out(hdr_nack_out),
        .prod_info_out(prod_info_out), .flow_out(flow_out),
        .temp_out(temp_out), .status_out(status_out));
    host_reader host_u (.clk_in(clk_in), .rst_in(rst_in), .en_in(host_en),
        .lag_in(8'h05), .avail_in(data_avail_out), .ack_in(hdr_ack_out),
        .rd_hdr_out(host_rd), .taken_out(taken), .reads_out(reads));
    // Free clock and cycle count used to time the block's answers.
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;
    task automatic stop_test();
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic pulse(input int b, input logic [15:0] a);
        @(posedge clk_in);
        cmd_v[b] <= 1'b1;
        cmd_arg <= a;
        @(posedge clk_in);
        cmd_v[b] <= 1'b0;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_in);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                mismatches++;
                stop_test();
            end
            @(posedge clk_in);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, e);
        bus(1'b0, a, 32'h0);
        `CHK("register", e, r)
    endtask
    // Waits for a rise of ready (0) or data available (1); gives its cycle.
    task automatic wait_rise(input int s, output int t);
        int n;
        n = 0;
        while (n < 400000 && (s ? data_avail_out : ready_out) === 1'b1) begin
            n++;
            @(posedge clk_in);
        end
        while (n < 400000 && (s ? data_avail_out : ready_out) !== 1'b1) begin
            n++;
            @(posedge clk_in);
        end
        if (n >= 400000) begin
            mismatches++;
            stop_test();
        end
        t = cyc;
    endtask
    initial begin
        {rst_in, scl, hsel, hwrite, host_en} = 5'b11000;
        {cmd_v, cmd_arg, haddr, hwdata, htrans} = 0;
        raw_flow = 16'hFED4;
        raw_temp = 16'h1234;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t0 = cyc;
        pulse(0, 16'h0);
        pulse(3, 16'h0001);
        rd_chk(32'h0, 32'h0);
        `CHK("heater", 1'b0, heater_out)
        wait_rise(0, t1);
        `CHK("ready time", 1'b1, t1 - t0 >= 50000 && t1 - t0 <= 50010)
        bus(1'b1, 32'h0, 32'h0000_01FF);
        rd_chk(32'h0, 32'h0);
        rd_chk(32'h4, 32'h11);
        rd_chk(32'h20, 32'h0);
        pulse(4, 16'hE102);
        #1 `CHK("product info", 1'b1, prod_info_out)
        pulse(4, 16'hE103);
        #1 `CHK("other code", 1'b0, prod_info_out)
        pulse(5, 16'h0);
        #1 `CHK("refusal", 2'b01, {hdr_ack_out, hdr_nack_out})
        foreach (rows[i]) begin
            pulse(3, rows[i].arg);
            rd_chk(32'h0, rows[i].cfg);
        end
        pulse(0, 16'h0);
        t0 = cyc;
        #1 `CHK("heater", 1'b1, heater_out)
        host_en <= 1'b1;
        wait_rise(1, t1);
        `CHK("first", 1'b1, t1 - t0 >= 300000 && t1 - t0 <= 300100)
        `CHK("mean", 16'hFED4, flow_out)
        `CHK("temperature", 16'h1234, temp_out)
        `CHK("status", 16'h13FF, status_out)
        rd_chk(32'h8, 32'hFFFF_FED4);
        rd_chk(32'h10, 32'h13FF);
        raw_flow <= 16'h02BC;
        pulse(3, 16'h0001);
        wait_rise(1, t1);
        wait_rise(1, t2);
        `CHK("period one", 1'b1, t2 - t1 >= 12499 && t2 - t1 <= 12501)
        `CHK("single", 16'h02BC, flow_out)
        `CHK("status", 16'h17FF, status_out)
        raw_flow <= 16'hFFA6;
        pulse(3, 16'h0003);
        wait_rise(1, t1);
        wait_rise(1, t2);
        `CHK("period three", 1'b1, t2 - t1 >= 37499 && t2 - t1 <= 37501)
        `CHK("fixed mean", 16'hFFA6, flow_out)
        `CHK("host reads", 1'b1, reads > 16'h3)
        host_en <= 1'b0;
        pulse(1, 16'h0);
        scl <= 1'b0;
        pulse(2, 16'h0);
        t0 = cyc;
        repeat (200) @(posedge clk_in);
        scl <= 1'b1;
        wait_rise(0, t1);
        `CHK("soft reset", 1'b1, t1 - t0 >= 50200 && t1 - t0 <= 50220)
        `CHK("heater", 1'b0, heater_out)
        rd_chk(32'h0, 32'h0);
        stop_test();
    end
endmodule // flow_averaging_tb
`default_nettype wire
